// [rtl/t16w_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "t16w_regs.svh"
module t16w_top (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        timer_tick_enable,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [15:0] reg_rdata,
   output logic             wave_out_a,
   output logic             wave_out_a_oe,
   output logic             wave_out_b,
   output logic             wave_out_b_oe,
   output logic             irq
);

   localparam int NCH = 2;

   // Register state
   logic [7:0]  ctrl_a_ff;
   logic [7:0]  nxt_ctrl_a;
   logic [1:0]  ctrl_b_ff;
   logic [1:0]  nxt_ctrl_b;
   logic [15:0] cap_ff;
   logic [15:0] nxt_cap;
   logic [1:0]  dir_ff;
   logic [1:0]  nxt_dir;
   logic [1:0]  pdata_ff;
   logic [1:0]  nxt_pdata;
   logic [2:0]  stat_ff;
   logic [2:0]  nxt_stat;
   logic [2:0]  mask_ff;
   logic [2:0]  nxt_mask;
   logic        irq_ff;
   logic        nxt_irq;
   logic [15:0] rdata_ff;
   logic [15:0] nxt_rdata;

   // Counter and compare state
   logic [15:0] cnt_ff;
   logic [15:0] nxt_cnt;
   logic        up_ff;
   logic        nxt_up;
   logic [15:0] buf_ff     [NCH];
   logic [15:0] nxt_buf    [NCH];
   logic [15:0] act_ff     [NCH];
   logic [15:0] nxt_act    [NCH];

   t16w_pkg::t16w_pin_t pin_ff  [NCH];
   t16w_pkg::t16w_pin_t nxt_pin [NCH];

   // Decoded mode and events
   t16w_pkg::t16w_mode_info_t info;
   logic [3:0]  waveform_mode_sel;
   logic [15:0] top_val;
   logic        dual;
   logic        immediate;
   logic        at_top;
   logic        at_bottom;
   logic        ovf_evt;
   logic        load_evt;
   logic [1:0]  match;
   logic [1:0]  cmp_at_top;
   logic [1:0]  wave;
   logic [1:0]  connected;
   logic [1:0]  omode [NCH];
   logic [2:0]  evt;
   logic [2:0]  clr;

   assign waveform_mode_sel = {ctrl_b_ff, ctrl_a_ff[`T16W_CTRLA_MODE_LO]};
   assign omode[0] = ctrl_a_ff[`T16W_CTRLA_OMODE_A];
   assign omode[1] = ctrl_a_ff[`T16W_CTRLA_OMODE_B];

   t16w_mode_dec u_dec (
      .waveform_mode_sel (waveform_mode_sel),
      .info              (info)
   );

   // Top value and mode class
   always_comb begin
      case (info.top_src)
         t16w_pkg::TOP_8BIT:    top_val = `T16W_TOP_8BIT;
         t16w_pkg::TOP_9BIT:    top_val = `T16W_TOP_9BIT;
         t16w_pkg::TOP_10BIT:   top_val = `T16W_TOP_10BIT;
         t16w_pkg::TOP_CMP_A:   top_val = act_ff[0];
         t16w_pkg::TOP_CAPTURE: top_val = cap_ff;
         default:               top_val = `T16W_MAX;
      endcase
      dual = (info.cls == t16w_pkg::CLS_PHASE) || (info.cls == t16w_pkg::CLS_PHFREQ);
      immediate = (info.cls == t16w_pkg::CLS_NORMAL) || (info.cls == t16w_pkg::CLS_CTC) ||
                  (info.cls == t16w_pkg::CLS_RSVD);
   end

   // Tick-qualified events
   always_comb begin
      at_top    = timer_tick_enable && (cnt_ff == top_val);
      at_bottom = timer_tick_enable && (cnt_ff == `T16W_BOTTOM);
      case (info.cls)
         t16w_pkg::CLS_NORMAL, t16w_pkg::CLS_CTC: begin
            ovf_evt  = timer_tick_enable && (cnt_ff == `T16W_MAX);
            load_evt = 1'b0;
         end
         t16w_pkg::CLS_PHASE: begin
            ovf_evt  = at_bottom;
            load_evt = at_top;
         end
         t16w_pkg::CLS_PHFREQ: begin
            ovf_evt  = at_bottom;
            load_evt = at_bottom;
         end
         t16w_pkg::CLS_FAST: begin
            ovf_evt  = at_top;
            load_evt = at_bottom;
         end
         default: begin
            ovf_evt  = 1'b0;
            load_evt = 1'b0;
         end
      endcase
   end

   // Counter sequence
   // A software write to the count wins over the tick in the same cycle.
   // Single slope wraps once the count reaches or passes top, so a top
   // lowered below the running count still wraps instead of running to max.
   // Dual slope turns at top and steps down on that same tick, so top
   // stands for one tick only and the period is twice top.
   // Leaving a dual-slope mode forces counting upward again.
   // Reserved mode 13 freezes the count; a count write still lands.
   always_comb begin
      nxt_cnt = cnt_ff;
      nxt_up  = up_ff;
      if (!dual) begin
         nxt_up = 1'b1;
      end
      if (reg_wr && reg_addr == `T16W_ADDR_COUNT) begin
         nxt_cnt = reg_wdata;
      end else if (timer_tick_enable && info.cls != t16w_pkg::CLS_RSVD) begin
         if (dual) begin
            if (up_ff) begin
               if (cnt_ff >= top_val) begin
                  nxt_up  = 1'b0;
                  nxt_cnt = (cnt_ff == `T16W_BOTTOM) ? cnt_ff : cnt_ff - 16'h0001;
               end else begin
                  nxt_cnt = cnt_ff + 16'h0001;
               end
            end else if (cnt_ff == `T16W_BOTTOM) begin
               nxt_up  = 1'b1;
               nxt_cnt = cnt_ff + 16'h0001;
            end else begin
               nxt_cnt = cnt_ff - 16'h0001;
            end
         end else if (info.cls != t16w_pkg::CLS_NORMAL && cnt_ff >= top_val) begin
            nxt_cnt = `T16W_BOTTOM;
         end else begin
            nxt_cnt = cnt_ff + 16'h0001;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cnt_ff <= `T16W_RST_WORD;
         up_ff  <= 1'b1;
      end else begin
         cnt_ff <= nxt_cnt;
         up_ff  <= nxt_up;
      end
   end

   // Per-channel compare, waveform and pin
   genvar gi;
   generate
      for (gi = 0; gi < NCH; gi++) begin : g_chan
         always_comb begin
            nxt_buf[gi] = buf_ff[gi];
            if (reg_wr && reg_addr == (`T16W_ADDR_CMP_A + 8'(gi))) begin
               nxt_buf[gi] = reg_wdata;
            end
            if (immediate) begin
               nxt_act[gi] = nxt_buf[gi];
            end else if (load_evt) begin
               nxt_act[gi] = buf_ff[gi];
            end else begin
               nxt_act[gi] = act_ff[gi];
            end
            match[gi]      = timer_tick_enable && (cnt_ff == act_ff[gi]);
            cmp_at_top[gi] = (act_ff[gi] == top_val);
            nxt_pin[gi].out = connected[gi] ? wave[gi] : pdata_ff[gi];
            nxt_pin[gi].oe  = dir_ff[gi];
         end

         t16w_out_chan #(
            .CHAN_A (gi == 0)
         ) u_chan (
            .clk        (clk),
            .sys_rst    (sys_rst),
            .info       (info),
            .out_mode   (omode[gi]),
            .match      (match[gi]),
            .at_bottom  (at_bottom),
            .up         (up_ff),
            .cmp_at_top (cmp_at_top[gi]),
            .wave       (wave[gi]),
            .connected  (connected[gi])
         );

         always_ff @(posedge clk) begin
            if (sys_rst) begin
               buf_ff[gi] <= `T16W_RST_WORD;
               act_ff[gi] <= `T16W_RST_WORD;
               pin_ff[gi] <= '0;
            end else begin
               buf_ff[gi] <= nxt_buf[gi];
               act_ff[gi] <= nxt_act[gi];
               pin_ff[gi] <= nxt_pin[gi];
            end
         end
      end
   endgenerate

   assign wave_out_a    = pin_ff[0].out;
   assign wave_out_a_oe = pin_ff[0].oe;
   assign wave_out_b    = pin_ff[1].out;
   assign wave_out_b_oe = pin_ff[1].oe;

   // Register file, status flags and read port
   // The interrupt follows the next status and mask, so it moves in step
   // with the flags and never lags a clear by an extra cycle.
   always_comb begin
      nxt_ctrl_a = ctrl_a_ff;
      nxt_ctrl_b = ctrl_b_ff;
      nxt_cap    = cap_ff;
      nxt_dir    = dir_ff;
      nxt_pdata  = pdata_ff;
      nxt_mask   = mask_ff;
      clr        = 3'h0;
      if (reg_wr) begin
         case (reg_addr)
            `T16W_ADDR_CTRL_A:    nxt_ctrl_a = reg_wdata[7:0] & `T16W_CTRLA_WR_MASK;
            `T16W_ADDR_CTRL_B:    nxt_ctrl_b = reg_wdata[`T16W_CTRLB_MODE_HI];
            `T16W_ADDR_CAPTOP:    nxt_cap    = reg_wdata;
            `T16W_ADDR_PORT_DIR:  nxt_dir    = reg_wdata[1:0];
            `T16W_ADDR_PORT_DATA: nxt_pdata  = reg_wdata[1:0];
            `T16W_ADDR_IRQ_MASK:  nxt_mask   = reg_wdata[2:0];
            `T16W_ADDR_IRQ_STAT:  clr        = reg_wdata[2:0];
            default:              clr        = 3'h0;
         endcase
      end
      evt = 3'h0;
      evt[`T16W_STAT_OVF]     = ovf_evt;
      evt[`T16W_STAT_MATCH_A] = match[0];
      evt[`T16W_STAT_MATCH_B] = match[1];
      // A new event in the clearing cycle keeps its flag
      nxt_stat = (stat_ff & ~clr) | evt;
      nxt_irq  = |(nxt_stat & nxt_mask);
      nxt_rdata = 16'h0000;
      if (reg_rd) begin
         case (reg_addr)
            `T16W_ADDR_CTRL_A:    nxt_rdata = {8'h00, ctrl_a_ff};
            `T16W_ADDR_CTRL_B:    nxt_rdata = {11'h000, ctrl_b_ff, 3'h0};
            `T16W_ADDR_COUNT:     nxt_rdata = cnt_ff;
            `T16W_ADDR_CMP_A:     nxt_rdata = buf_ff[0];
            `T16W_ADDR_CMP_B:     nxt_rdata = buf_ff[1];
            `T16W_ADDR_CAPTOP:    nxt_rdata = cap_ff;
            `T16W_ADDR_IRQ_STAT:  nxt_rdata = {13'h0000, stat_ff};
            `T16W_ADDR_IRQ_MASK:  nxt_rdata = {13'h0000, mask_ff};
            `T16W_ADDR_PORT_DIR:  nxt_rdata = {14'h0000, dir_ff};
            `T16W_ADDR_PORT_DATA: nxt_rdata = {14'h0000, pdata_ff};
            default:              nxt_rdata = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctrl_a_ff <= `T16W_RST_CTRL_A;
         ctrl_b_ff <= `T16W_RST_CTRL_B;
         cap_ff    <= `T16W_RST_WORD;
         dir_ff    <= 2'h0;
         pdata_ff  <= 2'h0;
         stat_ff   <= `T16W_RST_STAT;
         mask_ff   <= `T16W_RST_STAT;
         irq_ff    <= 1'b0;
         rdata_ff  <= `T16W_RST_WORD;
      end else begin
         ctrl_a_ff <= nxt_ctrl_a;
         ctrl_b_ff <= nxt_ctrl_b;
         cap_ff    <= nxt_cap;
         dir_ff    <= nxt_dir;
         pdata_ff  <= nxt_pdata;
         stat_ff   <= nxt_stat;
         mask_ff   <= nxt_mask;
         irq_ff    <= nxt_irq;
         rdata_ff  <= nxt_rdata;
      end
   end

   assign reg_rdata = rdata_ff;
   assign irq       = irq_ff;

endmodule // t16w_top
`default_nettype wire

// [common/t16w_regs.svh]
`ifndef T16W_REGS_SVH
`define T16W_REGS_SVH

// Register offsets (word per offset, 16-bit data port)
`define T16W_ADDR_CTRL_A     8'h2F
`define T16W_ADDR_CTRL_B     8'h2E
`define T16W_ADDR_COUNT      8'h30
`define T16W_ADDR_CMP_A      8'h31
`define T16W_ADDR_CMP_B      8'h32
`define T16W_ADDR_CAPTOP     8'h33
`define T16W_ADDR_IRQ_STAT   8'h34
`define T16W_ADDR_IRQ_MASK   8'h35
`define T16W_ADDR_PORT_DIR   8'h36
`define T16W_ADDR_PORT_DATA  8'h37

// Field positions
`define T16W_CTRLA_OMODE_A   7:6
`define T16W_CTRLA_OMODE_B   5:4
`define T16W_CTRLA_MODE_LO   1:0
`define T16W_CTRLA_WR_MASK   8'hF3
`define T16W_CTRLB_MODE_HI   4:3
`define T16W_STAT_OVF        0
`define T16W_STAT_MATCH_A    1
`define T16W_STAT_MATCH_B    2

// Reset values
`define T16W_RST_CTRL_A      8'h00
`define T16W_RST_CTRL_B      2'h0
`define T16W_RST_WORD        16'h0000
`define T16W_RST_STAT        3'h0

// Counter limits
`define T16W_BOTTOM          16'h0000
`define T16W_MAX             16'hFFFF
`define T16W_TOP_8BIT        16'h00FF
`define T16W_TOP_9BIT        16'h01FF
`define T16W_TOP_10BIT       16'h03FF

`endif

// [common/t16w_pkg.sv]
`default_nettype none
package t16w_pkg;

   typedef enum logic [2:0] {
      CLS_NORMAL,
      CLS_CTC,
      CLS_FAST,
      CLS_PHASE,
      CLS_PHFREQ,
      CLS_RSVD
   } t16w_cls_t;

   typedef enum logic [2:0] {
      TOP_FULL,
      TOP_8BIT,
      TOP_9BIT,
      TOP_10BIT,
      TOP_CMP_A,
      TOP_CAPTURE
   } t16w_top_src_t;

   typedef struct packed {
      t16w_cls_t     cls;
      t16w_top_src_t top_src;
      logic          msb;
   } t16w_mode_info_t;

   typedef struct packed {
      logic out;
      logic oe;
   } t16w_pin_t;

endpackage
`default_nettype wire

// [rtl/t16w_mode_dec.sv]
`timescale 1ns/1ps
`default_nettype none
module t16w_mode_dec (
   input  wire logic [3:0]              waveform_mode_sel,
   output var t16w_pkg::t16w_mode_info_t info
);

   always_comb begin
      info.msb     = waveform_mode_sel[3];
      info.cls     = t16w_pkg::CLS_RSVD;
      info.top_src = t16w_pkg::TOP_FULL;
      case (waveform_mode_sel)
         4'h0: begin
            info.cls = t16w_pkg::CLS_NORMAL;
         end
         4'h1: begin
            info.cls     = t16w_pkg::CLS_PHASE;
            info.top_src = t16w_pkg::TOP_8BIT;
         end
         4'h2: begin
            info.cls     = t16w_pkg::CLS_PHASE;
            info.top_src = t16w_pkg::TOP_9BIT;
         end
         4'h3: begin
            info.cls     = t16w_pkg::CLS_PHASE;
            info.top_src = t16w_pkg::TOP_10BIT;
         end
         4'h4: begin
            info.cls     = t16w_pkg::CLS_CTC;
            info.top_src = t16w_pkg::TOP_CMP_A;
         end
         4'h5: begin
            info.cls     = t16w_pkg::CLS_FAST;
            info.top_src = t16w_pkg::TOP_8BIT;
         end
         4'h6: begin
            info.cls     = t16w_pkg::CLS_FAST;
            info.top_src = t16w_pkg::TOP_9BIT;
         end
         4'h7: begin
            info.cls     = t16w_pkg::CLS_FAST;
            info.top_src = t16w_pkg::TOP_10BIT;
         end
         4'h8: begin
            info.cls     = t16w_pkg::CLS_PHFREQ;
            info.top_src = t16w_pkg::TOP_CAPTURE;
         end
         4'h9: begin
            info.cls     = t16w_pkg::CLS_PHFREQ;
            info.top_src = t16w_pkg::TOP_CMP_A;
         end
         4'hA: begin
            info.cls     = t16w_pkg::CLS_PHASE;
            info.top_src = t16w_pkg::TOP_CAPTURE;
         end
         4'hB: begin
            info.cls     = t16w_pkg::CLS_PHASE;
            info.top_src = t16w_pkg::TOP_CMP_A;
         end
         4'hC: begin
            info.cls     = t16w_pkg::CLS_CTC;
            info.top_src = t16w_pkg::TOP_CAPTURE;
         end
         4'hE: begin
            info.cls     = t16w_pkg::CLS_FAST;
            info.top_src = t16w_pkg::TOP_CAPTURE;
         end
         4'hF: begin
            info.cls     = t16w_pkg::CLS_FAST;
            info.top_src = t16w_pkg::TOP_CMP_A;
         end
         default: begin
            info.cls = t16w_pkg::CLS_RSVD;
         end
      endcase
   end

endmodule // t16w_mode_dec
`default_nettype wire

// [rtl/t16w_out_chan.sv]
`timescale 1ns/1ps
`default_nettype none
module t16w_out_chan #(
   parameter bit CHAN_A = 1'b1
) (
   input  wire logic                      clk,
   input  wire logic                      sys_rst,
   input  wire t16w_pkg::t16w_mode_info_t info,
   input  wire logic [1:0]                out_mode,
   input  wire logic                      match,
   input  wire logic                      at_bottom,
   input  wire logic                      up,
   input  wire logic                      cmp_at_top,
   output logic                           wave,
   output logic                           connected
);

   logic wave_ff;
   logic nxt_wave;
   logic pwm;

   assign wave = wave_ff;

   always_comb begin
      pwm = (info.cls == t16w_pkg::CLS_FAST) || (info.cls == t16w_pkg::CLS_PHASE) ||
            (info.cls == t16w_pkg::CLS_PHFREQ);
      connected = (out_mode != 2'b00);
      if (pwm && out_mode == 2'b01 && !(info.msb && CHAN_A)) begin
         connected = 1'b0;
      end
      nxt_wave = wave_ff;
      case (info.cls)
         t16w_pkg::CLS_NORMAL, t16w_pkg::CLS_CTC: begin
            if (match) begin
               case (out_mode)
                  2'b01:   nxt_wave = ~wave_ff;
                  2'b10:   nxt_wave = 1'b0;
                  2'b11:   nxt_wave = 1'b1;
                  default: nxt_wave = wave_ff;
               endcase
            end
         end
         t16w_pkg::CLS_FAST: begin
            if (out_mode == 2'b01) begin
               if (connected && match) begin
                  nxt_wave = ~wave_ff;
               end
            end else if (out_mode[1]) begin
               if (at_bottom) begin
                  nxt_wave = ~out_mode[0];
               end else if (match && !cmp_at_top) begin
                  nxt_wave = out_mode[0];
               end
            end
         end
         t16w_pkg::CLS_PHASE, t16w_pkg::CLS_PHFREQ: begin
            if (match) begin
               if (out_mode == 2'b01) begin
                  nxt_wave = connected ? ~wave_ff : wave_ff;
               end else if (out_mode[1]) begin
                  nxt_wave = up ? out_mode[0] : ~out_mode[0];
               end
            end
         end
         default: nxt_wave = wave_ff;
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wave_ff <= 1'b0;
      end else begin
         wave_ff <= nxt_wave;
      end
   end

endmodule // t16w_out_chan
`default_nettype wire

// [tb/t16w_top_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module t16w_top_monitor (
   input wire logic        clk,
   input wire logic        sys_rst,
   input wire logic        timer_tick_enable,
   input wire logic [7:0]  reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic        wave_out_a,
   input wire logic        wave_out_a_oe,
   input wire logic        wave_out_b,
   input wire logic        wave_out_b_oe,
   input wire logic        irq
);
   default clocking mon_cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   sequence s_ctrl_rd;
      reg_rd && reg_addr == 8'h2F;
   endsequence
   sequence s_mask_off;
      reg_wr && reg_addr == 8'h35 && reg_wdata[2:0] == 3'h0;
   endsequence

   a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
      else $error("read data not zero outside read cycle");
   a_ctrl_resv_zero: assert property (s_ctrl_rd |=> reg_rdata[15:8] == 8'h00 && reg_rdata[3:2] == 2'h0)
      else $error("reserved control bits read nonzero");
   a_unmapped_rd_zero: assert property (reg_rd && reg_addr == 8'h00 |=> reg_rdata == 16'h0000)
      else $error("unmapped read returned data");
   a_oe_a_cause: assert property ($changed(wave_out_a_oe) |-> $past(reg_wr && reg_addr == 8'h36) || $past(reg_wr && reg_addr == 8'h36, 2))
      else $error("pin A enable changed without direction write");
   a_oe_b_cause: assert property ($changed(wave_out_b_oe) |-> $past(reg_wr && reg_addr == 8'h36) || $past(reg_wr && reg_addr == 8'h36, 2))
      else $error("pin B enable changed without direction write");
   a_pin_a_cause: assert property ($changed(wave_out_a) |-> $past(timer_tick_enable) || $past(timer_tick_enable, 2) || $past(reg_wr) || $past(reg_wr, 2) || $past(reg_wr, 3))
      else $error("pin A changed without tick or write");
   a_pin_b_cause: assert property ($changed(wave_out_b) |-> $past(timer_tick_enable) || $past(timer_tick_enable, 2) || $past(reg_wr) || $past(reg_wr, 2) || $past(reg_wr, 3))
      else $error("pin B changed without tick or write");
   a_irq_rise_cause: assert property ($rose(irq) |-> $past(timer_tick_enable) || $past(reg_wr))
      else $error("interrupt rose without tick or write");
   a_irq_fall_cause: assert property ($fell(irq) |-> $past(reg_wr && (reg_addr == 8'h34 || reg_addr == 8'h35)))
      else $error("interrupt fell without clear or mask");
   a_mask_off_quiet: assert property (s_mask_off |=> !irq)
      else $error("interrupt high with mask cleared");
endmodule // t16w_top_monitor

bind t16w_top t16w_top_monitor mon (.clk(clk), .sys_rst(sys_rst), .timer_tick_enable(timer_tick_enable),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .wave_out_a(wave_out_a), .wave_out_a_oe(wave_out_a_oe),
   .wave_out_b(wave_out_b), .wave_out_b_oe(wave_out_b_oe), .irq(irq));
`default_nettype wire

// [tb/t16w_pin_load.sv]
`timescale 1ns/1ps
`default_nettype none
module t16w_pin_load (
   input  wire logic drv_val,
   input  wire logic drv_en,
   output logic      pin_level
);
   // Pull-down holds an undriven pin low
   assign pin_level = drv_en ? drv_val : 1'b0;
endmodule // t16w_pin_load
`default_nettype wire

// [tb/t16w_top_test.sv]
`timescale 1ns/1ps
`default_nettype none
`include "t16w_regs.svh"
`define CHECK(got, exp) begin num_checks++; if ((got) !== (exp)) begin errors++; \
   $display("[ERR] %0t mismatch got %0h exp %0h", $time, got, exp); end end
module t16w_top_test;
   logic        clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        tick = 1'b1;
   logic [7:0]  reg_addr = 8'h00;
   logic [15:0] reg_wdata = 16'h0000;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic        rand_tick = 1'b0;
   logic [63:0] tick_pat;
   logic [15:0] reg_rdata, c, t, d, tp, cv;
   logic        wave_a, oe_a, wave_b, oe_b, irq, pin_a, pin_b;
   int          errors = 0;
   int          num_checks = 0;
   int          cycles = 0;
   int          hi, w;
   int          rows[15][4] = '{'{5,2,255,0}, '{5,3,255,0}, '{6,2,511,0}, '{7,2,1023,0},
      '{5,2,255,1}, '{14,2,0,0}, '{14,1,0,0}, '{1,2,255,0}, '{2,2,511,0}, '{3,3,1023,0},
      '{8,2,0,0}, '{10,3,0,0}, '{4,1,1,0}, '{12,1,0,0}, '{5,1,255,0}};
   logic [1:0]  om_seq[3] = '{2'h3, 2'h2, 2'h1};
   logic        exp_seq[3] = '{1'b1, 1'b0, 1'b1};

   t16w_top dut (.clk(clk), .sys_rst(sys_rst), .timer_tick_enable(tick), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .wave_out_a(wave_a), .wave_out_a_oe(oe_a), .wave_out_b(wave_b), .wave_out_b_oe(oe_b),
      .irq(irq));
   t16w_pin_load load_a (.drv_val(wave_a), .drv_en(oe_a), .pin_level(pin_a));
   t16w_pin_load load_b (.drv_val(wave_b), .drv_en(oe_b), .pin_level(pin_b));

   always #5 clk = ~clk;

   always @(posedge clk) begin
      cycles++;
      tick <= rand_tick ? tick_pat[cycles[5:0]] : 1'b1;
      if (cycles == 90000) begin
         errors++;
         complete_run();
      end
   end

   task automatic complete_run();
      $display("errors %0d checks %0d", errors, num_checks);
      if (errors == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] v);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [15:0] v);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      // Read data stand only until the next rising edge, so take them mid-cycle
      @(negedge clk);
      v = reg_rdata;
   endtask

   // Park in mode 0 so compare writes land at once and counting restarts upward
   task automatic setup(input int m, input int om, input logic [15:0] cmp, input logic [15:0] top);
      wr(`T16W_ADDR_CTRL_A, 16'h0000);
      wr(`T16W_ADDR_CTRL_B, 16'h0000);
      wr(`T16W_ADDR_CAPTOP, top);
      wr(`T16W_ADDR_CMP_A, cmp);
      wr(`T16W_ADDR_CTRL_B, {11'h000, 2'(m >> 2), 3'h0});
      wr(`T16W_ADDR_CTRL_A, {8'h00, 2'(om), 4'h0, 2'(m)});
      wr(`T16W_ADDR_COUNT, 16'h0000);
   endtask

   function automatic int win_of(int m, int om, int top);
      if (m inside {1, 2, 3, 8, 10}) return 2 * top;
      if (om == 1) return 2 * top + 2;
      return top + 1;
   endfunction

   function automatic int exp_of(int m, int om, int cmp, int top, int win);
      if (m == 5 && om == 1) return win;
      if (om == 1) return top + 1;
      if (m inside {1, 2, 3, 8, 10}) return (om == 2) ? 2 * cmp : win - 2 * cmp;
      if (om == 2) return (cmp == top) ? win : cmp;
      return win - cmp;
   endfunction

   initial begin
      void'($urandom(39));
      tick_pat = {$urandom, $urandom};
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      rd(`T16W_ADDR_CTRL_A, d);
      `CHECK(d, 16'h0000)
      wr(`T16W_ADDR_CTRL_A, 16'hFFFF);
      rd(`T16W_ADDR_CTRL_A, d);
      `CHECK(d, 16'h00F3)
      rd(8'h00, d);
      `CHECK(d, 16'h0000)
      wr(`T16W_ADDR_CTRL_A, 16'h0000);
      wr(`T16W_ADDR_PORT_DATA, 16'h0003);
      wr(`T16W_ADDR_PORT_DIR, 16'h0000);
      repeat (3) @(posedge clk);
      `CHECK({oe_a, oe_b, pin_a}, 3'h0)
      wr(`T16W_ADDR_PORT_DIR, 16'h0003);
      repeat (3) @(posedge clk);
      `CHECK({oe_a, oe_b, pin_a, pin_b}, 4'hF)
      // Normal mode match actions under an irregular tick
      c = 16'(8 + $urandom % 93);
      rand_tick <= 1'b1;
      for (int k = 0; k < 3; k++) begin
         setup(0, om_seq[k], c, 16'h0000);
         repeat (8 * c + 100) @(posedge clk);
         `CHECK(pin_a, exp_seq[k])
      end
      rd(`T16W_ADDR_IRQ_STAT, d);
      `CHECK(d[1], 1'b1)
      wr(`T16W_ADDR_IRQ_MASK, 16'h0002);
      repeat (2) @(posedge clk);
      `CHECK(irq, 1'b1)
      wr(`T16W_ADDR_IRQ_MASK, 16'h0000);
      repeat (2) @(posedge clk);
      `CHECK(irq, 1'b0)
      wr(`T16W_ADDR_IRQ_MASK, 16'h0002);
      wr(`T16W_ADDR_IRQ_STAT, 16'h0007);
      repeat (2) @(posedge clk);
      `CHECK(irq, 1'b0)
      rand_tick <= 1'b0;
      // Duty per mode over one full period measures top, slope and output action
      t = 16'(c + 20 + $urandom % 101);
      for (int r = 0; r < 15; r++) begin
         tp = (rows[r][2] == 0) ? t : (rows[r][2] == 1) ? c : 16'(rows[r][2]);
         cv = rows[r][3] ? tp : c;
         setup(rows[r][0], rows[r][1], cv, tp);
         w = win_of(rows[r][0], rows[r][1], int'(tp));
         repeat (w + 8) @(posedge clk);
         hi = 0;
         repeat (w) begin
            @(posedge clk);
            hi += int'(pin_a);
         end
         `CHECK(hi, exp_of(rows[r][0], rows[r][1], int'(cv), int'(tp), w))
      end
      setup(13, 0, c, t);
      repeat (20) @(posedge clk);
      rd(`T16W_ADDR_COUNT, d);
      `CHECK(d, 16'h0000)
      complete_run();
   end
endmodule // t16w_top_test
`default_nettype wire
